// ---- hdl/led_engine_exec_control.sv ----
// register bank and control for chip enable and the three execution engines
// What this block does
// [R1] Chip enable low: standby; exec bits, pc registers blocked, others stay accessible.
// [R2] Chip enable high starts a startup sequence, then normal mode.
// [R3] Register zero holds three 2-bit exec fields at 5:4, 3:2, 1:0.
// [R4] Program counter registers at 0x37, 0x38, 0x39 load start addresses.
// [R5] Hold finishes current instruction then stops; pc accessible only in hold.
// [R6] Step runs one instruction, increments pc, returns field to hold.
// [R7] Free run executes continuously from the current pc.
// [R8] Execute once runs one instruction, pc unchanged, field back to hold.
// [R9] Each engine can be disabled independently of the others.
// [R10] Program writes accepted only in load mode with busy flag clear.
// [R11] Host polls busy flag clear before writing program memory.
// [R12] Any engine loading holds all engines and freezes pwm values.
// [R13] Entering load mode clears that engine's program counter.
// [R14] Load mode entered only from disabled, never straight from run.
// [R15] Run mode executes program as selected by the exec field.
// [R16] Program counter wraps to zero past its upper limit.
// [R17] Halt aborts the current instruction immediately and stops the engine.
// [R18] Register one holds 2-bit mode fields: disabled, load, run, halt.
// [R19] Load request while engine not disabled is ignored; mode unchanged.
module led_engine_exec_control
    import led_exec_pkg::*;
#(
    parameter int STARTUP_CNT = STARTUP_CYCLES
) (
    input  wire logic                   CLK,          // 40 MHz device clock
    input  wire logic                   SYS_RST,      // async reset, active high
    input  wire logic                   REG_WE,       // register write strobe
    input  wire logic                   REG_RE,       // register read strobe
    input  wire logic [7:0]             REG_ADDR,     // register offset
    input  wire logic [7:0]             REG_WDATA,    // register write data
    output logic      [7:0]             REG_RDATA,    // register read data
    input  wire logic                   PROG_WR_REQ,  // program memory write request
    input  wire logic [1:0]             PROG_WR_ENG,  // target engine, 0 is first
    output logic                        PROG_WR_ACK,  // write accepted, pulse
    output logic                        PROG_WR_NAK,  // write refused, pulse
    input  wire logic [NUM_ENGINES-1:0] INSTR_DONE,   // datapath instruction done
    output logic      [NUM_ENGINES-1:0] EXEC_GO,      // start instruction, pulse
    output logic      [NUM_ENGINES-1:0] EXEC_ABORT,   // abort instruction, pulse
    output logic      [PC_W-1:0]        ENG1_PC,      // first engine pc
    output logic      [PC_W-1:0]        ENG2_PC,      // second engine pc
    output logic      [PC_W-1:0]        ENG3_PC,      // third engine pc
    output logic                        PWM_FREEZE,   // pwm values frozen
    output logic                        POWER_UP,     // internal blocks powered
    output logic                        NORMAL_MODE   // normal operating mode
);

    import led_exec_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic                   chip_en_ff;
    logic                   nxt_chip_en;
    logic [FIELDS_W-1:0]    exec_ff;
    logic [FIELDS_W-1:0]    nxt_exec;
    logic [FIELDS_W-1:0]    mode_ff;
    logic [FIELDS_W-1:0]    nxt_mode;
    logic [7:0]             rdata_ff;
    logic [7:0]             nxt_rdata;
    logic                   ack_ff;
    logic                   nxt_ack;
    logic                   nak_ff;
    logic                   nxt_nak;
    logic                   freeze_ff;
    logic                   nxt_freeze;
    logic [NUM_ENGINES-1:0] load_enter;
    logic [NUM_ENGINES-1:0] pc_wr;
    logic [NUM_ENGINES-1:0] pc_open;
    logic [NUM_ENGINES-1:0] run_allow;
    logic [NUM_ENGINES-1:0] stop_req;
    logic [NUM_ENGINES-1:0] eng_busy;
    logic [NUM_ENGINES-1:0] exec_done;
    logic [NUM_ENGINES-1:0] is_load;
    logic [PC_W-1:0]        pc_val [NUM_ENGINES];
    logic                   any_load;
    logic                   any_busy;
    logic                   normal;
    logic                   power_up;
    logic [1:0]             req_mode;
    logic [1:0]             tgt_mode;

    assign any_load = |is_load;
    assign any_busy = |eng_busy;

    // ------------------------------------------------------------
    // per engine decode and engine instances
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_ENGINES; g++) begin : g_eng
            localparam int HI = FIELD_TOP_BIT - FIELD_W * g;
            logic [1:0] mode_f;
            logic [1:0] exec_f;
            assign mode_f        = mode_ff[HI -: FIELD_W];
            assign exec_f        = exec_ff[HI -: FIELD_W];
            assign is_load[g]    = (mode_f == MODE_LOAD);
            assign pc_open[g]    = chip_en_ff && (exec_f == EXEC_HOLD) && !eng_busy[g]; // R1 R5
            assign pc_wr[g]      = REG_WE && pc_open[g] && (REG_ADDR == ADDR_PC_FIRST + 8'(g)); // R4
            assign load_enter[g] = REG_WE && (REG_ADDR == ADDR_OP_MODE) && (mode_f == MODE_DISABLED)
                                   && (REG_WDATA[HI -: FIELD_W] == MODE_LOAD); // R13 R14
            assign run_allow[g]  = normal && (mode_f == MODE_RUN) && !any_load; // R12 R15
            assign stop_req[g]   = (mode_f == MODE_HALT) || (mode_f == MODE_DISABLED); // R9 R17
            led_exec_engine u_eng (
                .clk        (CLK),
                .rst        (SYS_RST),
                .run_allow  (run_allow[g]),
                .stop_req   (stop_req[g]),
                .exec_ctrl  (exec_f),
                .load_enter (load_enter[g]),
                .pc_wr      (pc_wr[g]),
                .pc_wdata   (REG_WDATA[PC_W-1:0]),
                .instr_done (INSTR_DONE[g]),
                .pc         (pc_val[g]),
                .go         (EXEC_GO[g]),
                .abort      (EXEC_ABORT[g]),
                .busy       (eng_busy[g]),
                .exec_done  (exec_done[g])
            );
        end
    endgenerate

    led_startup_seq #(
        .STARTUP_CNT (STARTUP_CNT)
    ) u_start (
        .clk      (CLK),
        .rst      (SYS_RST),
        .chip_en  (chip_en_ff),
        .power_up (power_up),
        .normal   (normal)
    );

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_comb begin
        nxt_chip_en = chip_en_ff;
        nxt_exec    = exec_ff;
        nxt_mode    = mode_ff;
        req_mode    = MODE_DISABLED;
        tgt_mode    = MODE_DISABLED;
        // step and once return their field to hold
        for (int i = 0; i < NUM_ENGINES; i++) begin
            if (exec_done[i]) begin
                nxt_exec[FIELD_TOP_BIT - FIELD_W * i -: FIELD_W] = EXEC_HOLD; // R6 R8
            end
        end
        if (REG_WE && REG_ADDR == ADDR_ENABLE_EXEC) begin
            nxt_chip_en = REG_WDATA[CHIP_EN_BIT]; // R2
            if (chip_en_ff) begin
                nxt_exec = REG_WDATA[FIELDS_W-1:0]; // R1 R3
            end
        end else if (REG_WE && REG_ADDR == ADDR_OP_MODE) begin
            for (int i = 0; i < NUM_ENGINES; i++) begin
                req_mode = REG_WDATA[FIELD_TOP_BIT - FIELD_W * i -: FIELD_W];
                tgt_mode = mode_ff[FIELD_TOP_BIT - FIELD_W * i -: FIELD_W];
                if (!(req_mode == MODE_LOAD && tgt_mode != MODE_DISABLED)) begin
                    nxt_mode[FIELD_TOP_BIT - FIELD_W * i -: FIELD_W] = req_mode; // R9 R18 R19
                end
            end
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always_comb begin
        nxt_rdata = rdata_ff;
        if (REG_RE) begin
            if (REG_ADDR == ADDR_ENABLE_EXEC) begin
                nxt_rdata = {1'b0, chip_en_ff, exec_ff};
            end else if (REG_ADDR == ADDR_OP_MODE) begin
                nxt_rdata = {2'b00, mode_ff};
            end else if (REG_ADDR == ADDR_PC_FIRST) begin
                nxt_rdata = pc_open[0] ? {1'b0, pc_val[0]} : 8'h00; // R5
            end else if (REG_ADDR == ADDR_PC_SECOND) begin
                nxt_rdata = pc_open[1] ? {1'b0, pc_val[1]} : 8'h00; // R5
            end else if (REG_ADDR == ADDR_PC_THIRD) begin
                nxt_rdata = pc_open[2] ? {1'b0, pc_val[2]} : 8'h00; // R5
            end else if (REG_ADDR == ADDR_STATUS) begin
                nxt_rdata = 8'h00;
                nxt_rdata[BUSY_BIT] = any_busy;
            end else begin
                nxt_rdata = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // program memory write gate and pwm freeze
    // ------------------------------------------------------------
    always_comb begin
        nxt_ack    = 1'b0;
        nxt_nak    = 1'b0;
        nxt_freeze = any_load; // R12
        if (PROG_WR_REQ) begin
            if (PROG_WR_ENG < 2'(NUM_ENGINES) && is_load[PROG_WR_ENG] && !any_busy) begin
                nxt_ack = 1'b1; // R10
            end else begin
                nxt_nak = 1'b1; // R10
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            chip_en_ff <= CTRL_RESET[CHIP_EN_BIT];
            exec_ff    <= CTRL_RESET[FIELDS_W-1:0];
            mode_ff    <= MODE_RESET;
            rdata_ff   <= 8'h00;
            ack_ff     <= 1'b0;
            nak_ff     <= 1'b0;
            freeze_ff  <= 1'b0;
        end else begin
            chip_en_ff <= nxt_chip_en;
            exec_ff    <= nxt_exec;
            mode_ff    <= nxt_mode;
            rdata_ff   <= nxt_rdata;
            ack_ff     <= nxt_ack;
            nak_ff     <= nxt_nak;
            freeze_ff  <= nxt_freeze;
        end
    end

    assign REG_RDATA   = rdata_ff;
    assign PROG_WR_ACK = ack_ff;
    assign PROG_WR_NAK = nak_ff;
    assign ENG1_PC     = pc_val[0];
    assign ENG2_PC     = pc_val[1];
    assign ENG3_PC     = pc_val[2];
    assign PWM_FREEZE  = freeze_ff;
    assign POWER_UP    = power_up;
    assign NORMAL_MODE = normal;

endmodule // led_engine_exec_control

// ---- hdl/led_exec_engine.sv ----
// one program execution engine: issue, completion, abort and program counter
module led_exec_engine
    import led_exec_pkg::*;
(
    input  wire logic            clk,        // device clock
    input  wire logic            rst,        // async reset, active high
    input  wire logic            run_allow,  // run mode, normal, no engine loading
    input  wire logic            stop_req,   // halt or disabled: abort at once
    input  wire logic [1:0]      exec_ctrl,  // execution control field
    input  wire logic            load_enter, // entering load program mode
    input  wire logic            pc_wr,      // host pc write
    input  wire logic [PC_W-1:0] pc_wdata,   // host pc value
    input  wire logic            instr_done, // datapath finished instruction
    output logic      [PC_W-1:0] pc,         // program counter
    output logic                 go,         // start instruction at pc, pulse
    output logic                 abort,      // abort instruction, pulse
    output logic                 busy,       // instruction in progress
    output logic                 exec_done   // step or once finished, pulse
);

    typedef enum logic [1:0] {
        E_IDLE = 2'h0,
        E_BUSY = 2'h1,
        E_DONE = 2'h3
    } eng_state_e;

    eng_state_e      state_ff;
    eng_state_e      nxt_state;
    logic [1:0]      kind_ff;
    logic [1:0]      nxt_kind;
    logic [PC_W-1:0] pc_ff;
    logic [PC_W-1:0] nxt_pc;
    logic [PC_W-1:0] pc_inc;
    logic            go_ff;
    logic            nxt_go;
    logic            abort_ff;
    logic            nxt_abort;
    logic            busy_ff;
    logic            done_ff;
    logic            nxt_done;

    assign pc_inc = (pc_ff == PC_LAST) ? PC_ZERO : pc_ff + PC_ONE; // R16

    // ------------------------------------------------------------
    // engine sequence
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_kind  = kind_ff;
        nxt_pc    = pc_ff;
        nxt_go    = 1'b0;
        nxt_abort = 1'b0;
        nxt_done  = 1'b0;
        case (state_ff)
            E_IDLE: begin
                if (load_enter) begin
                    nxt_pc = PC_ZERO; // R13
                end else if (pc_wr) begin
                    nxt_pc = pc_wdata; // R4 R5
                end else if (run_allow && exec_ctrl != EXEC_HOLD) begin
                    nxt_go    = 1'b1; // R7 R15
                    nxt_kind  = exec_ctrl;
                    nxt_state = E_BUSY;
                end
            end
            E_BUSY: begin
                if (stop_req) begin
                    nxt_abort = 1'b1; // R17
                    nxt_state = E_IDLE;
                end else if (instr_done) begin
                    case (kind_ff)
                        EXEC_STEP: begin
                            nxt_pc    = pc_inc; // R6
                            nxt_done  = 1'b1;
                            nxt_state = E_DONE;
                        end
                        EXEC_ONCE: begin
                            nxt_done  = 1'b1; // R8
                            nxt_state = E_DONE;
                        end
                        default: begin
                            nxt_pc    = pc_inc; // R7
                            nxt_state = E_IDLE;
                        end
                    endcase
                end
            end
            E_DONE: begin
                // field is cleared by the bank during this cycle
                nxt_state = E_IDLE;
            end
            default: begin
                nxt_state = E_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= E_IDLE;
            kind_ff  <= EXEC_HOLD;
            pc_ff    <= PC_ZERO;
            go_ff    <= 1'b0;
            abort_ff <= 1'b0;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            kind_ff  <= nxt_kind;
            pc_ff    <= nxt_pc;
            go_ff    <= nxt_go;
            abort_ff <= nxt_abort;
            busy_ff  <= (nxt_state == E_BUSY);
            done_ff  <= nxt_done;
        end
    end

    assign pc        = pc_ff;
    assign go        = go_ff;
    assign abort     = abort_ff;
    assign busy      = busy_ff;
    assign exec_done = done_ff;

endmodule // led_exec_engine

// ---- hdl/led_exec_pkg.sv ----
// constants, field layouts and codes for the led engine execution control block
package led_exec_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE_EXEC = 8'h00;
    localparam logic [7:0] ADDR_OP_MODE     = 8'h01;
    localparam logic [7:0] ADDR_PC_FIRST    = 8'h37;
    localparam logic [7:0] ADDR_PC_SECOND   = 8'h38;
    localparam logic [7:0] ADDR_PC_THIRD    = 8'h39;
    localparam logic [7:0] ADDR_STATUS      = 8'h3a;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int         NUM_ENGINES     = 3;
    localparam int         CHIP_EN_BIT     = 6;
    localparam int         FIELD_W         = 2;
    localparam int         FIELDS_W        = 6;
    localparam int         FIELD_TOP_BIT   = 5;
    localparam int         BUSY_BIT        = 4;
    localparam logic [6:0] CTRL_RESET      = 7'h00;
    localparam logic [5:0] MODE_RESET      = 6'h00;

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    localparam int         PC_W            = 7;
    localparam logic [6:0] PC_ZERO         = 7'h00;
    localparam logic [6:0] PC_ONE          = 7'h01;
    localparam logic [6:0] PC_LAST         = 7'h5f;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EXEC_HOLD = 2'h0,
        EXEC_STEP = 2'h1,
        EXEC_FREE = 2'h2,
        EXEC_ONCE = 2'h3
    } exec_code_e;

    typedef enum logic [1:0] {
        MODE_DISABLED = 2'h0,
        MODE_LOAD     = 2'h1,
        MODE_RUN      = 2'h2,
        MODE_HALT     = 2'h3
    } op_mode_e;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 25;
    localparam int STARTUP_TIME_NS = 500000;
    localparam int STARTUP_CYCLES  = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_CNT_W   = 16;

endpackage

// ---- hdl/led_startup_seq.sv ----
// startup sequencer: standby, power-up wait and normal operation
module led_startup_seq
    import led_exec_pkg::*;
#(
    parameter int STARTUP_CNT = STARTUP_CYCLES
) (
    input  wire logic clk,      // device clock
    input  wire logic rst,      // async reset, active high
    input  wire logic chip_en,  // chip enable bit
    output logic      power_up, // internal blocks powered
    output logic      normal    // normal operating mode reached
);

    typedef enum logic [1:0] {
        S_OFF    = 2'h0,
        S_START  = 2'h1,
        S_NORMAL = 2'h3
    } start_state_e;

    start_state_e             state_ff;
    start_state_e             nxt_state;
    logic [STARTUP_CNT_W-1:0] cnt_ff;
    logic [STARTUP_CNT_W-1:0] nxt_cnt;
    logic                     power_up_ff;
    logic                     nxt_power_up;
    logic                     normal_ff;
    logic                     nxt_normal;

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            S_OFF: begin
                nxt_cnt = '0;
                if (chip_en) begin
                    nxt_state = S_START; // R2
                end
            end
            S_START: begin
                if (!chip_en) begin
                    nxt_state = S_OFF;
                end else if (cnt_ff == STARTUP_CNT_W'(STARTUP_CNT - 1)) begin
                    nxt_state = S_NORMAL; // R2
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            S_NORMAL: begin
                if (!chip_en) begin
                    nxt_state = S_OFF; // R1
                end
            end
            default: begin
                nxt_state = S_OFF;
            end
        endcase
        nxt_power_up = (nxt_state != S_OFF);
        nxt_normal   = (nxt_state == S_NORMAL);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff    <= S_OFF;
            cnt_ff      <= '0;
            power_up_ff <= 1'b0;
            normal_ff   <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            power_up_ff <= nxt_power_up;
            normal_ff   <= nxt_normal;
        end
    end

    assign power_up = power_up_ff;
    assign normal   = normal_ff;

endmodule // led_startup_seq

// ---- verif/led_datapath_model.sv ----
// instruction datapath model: one done pulse per start, none after abort
module led_datapath_model (
    input  wire logic       clk,   // clock
    input  wire logic       rst,   // reset
    input  wire logic [3:0] dly,   // start to done cycles
    input  wire logic [2:0] go,    // start pulses
    input  wire logic [2:0] abort, // abort drops the instruction
    output logic      [2:0] done   // done pulses
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] left_ff [3];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_ff <= '{default: 4'h0};
            done    <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                done[i] <= (left_ff[i] == 4'h1) && !abort[i] && !go[i];
                if (go[i]) left_ff[i] <= dly;
                else if (abort[i] || left_ff[i] == 4'h0) left_ff[i] <= 4'h0;
                else left_ff[i] <= left_ff[i] - 4'h1;
            end
        end
    end
endmodule // led_datapath_model

// ---- verif/led_exec_checker_sva.sv ----
// assertions on the ports of the led engine execution control block
module led_exec_checker
    import led_exec_pkg::*;
#(
    parameter int STARTUP_CNT = STARTUP_CYCLES
) (
    input wire logic       CLK,         // clock
    input wire logic       SYS_RST,     // reset
    input wire logic       REG_WE,      // write strobe
    input wire logic       PROG_WR_REQ, // program write
    input wire logic       PROG_WR_ACK, // accepted
    input wire logic       PROG_WR_NAK, // refused
    input wire logic [2:0] EXEC_GO,     // start pulses
    input wire logic [2:0] EXEC_ABORT,  // abort pulses
    input wire logic [6:0] ENG1_PC,     // first pc
    input wire logic       PWM_FREEZE,  // frozen
    input wire logic       POWER_UP,    // powered
    input wire logic       NORMAL_MODE  // normal
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // startup wait counter and checks
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic [15:0] wait_ff, nxt_wait;
    always_comb nxt_wait = (POWER_UP && !NORMAL_MODE) ? wait_ff + 16'h1 : 16'h0;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) wait_ff <= 16'h0;
        else wait_ff <= nxt_wait;
    end
    sequence prog_asked; PROG_WR_REQ; endsequence
    sequence one_answer; PROG_WR_ACK ^ PROG_WR_NAK; endsequence
    a_prog_answer: assert property (prog_asked |=> one_answer)
        else $error("program write not answered once");
    a_go_normal: assert property (|EXEC_GO |-> $past(NORMAL_MODE))
        else $error("start outside normal mode");
    a_go_frozen: assert property (|EXEC_GO |-> !PWM_FREEZE)
        else $error("start while frozen");
    a_go_spacing: assert property ((EXEC_GO & ($past(EXEC_GO) | $past(EXEC_GO, 2))) == 3'h0)
        else $error("starts too close");
    a_abort_no_go: assert property ((EXEC_ABORT & EXEC_GO) == 3'h0)
        else $error("start with abort");
    a_pc_advance: assert property (
        !$past(REG_WE) && !$past(REG_WE, 2) && ENG1_PC != $past(ENG1_PC)
        |-> ENG1_PC == (($past(ENG1_PC) == PC_LAST) ? PC_ZERO : $past(ENG1_PC) + PC_ONE))
        else $error("pc moved other than by one");
    a_startup_bound: assert property (wait_ff <= STARTUP_CNT + 1)
        else $error("startup too long");
    a_normal_after: assert property (
        $rose(NORMAL_MODE) |-> $past(POWER_UP) && $past(wait_ff) + 2 >= STARTUP_CNT)
        else $error("normal mode too early");
endmodule // led_exec_checker

// ---- verif/testbench.sv ----
// self-checking bench for the led engine execution control block
module testbench
    import led_exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // signals, instances and tasks
    // ----------------------------------------
    localparam int STARTUP_CNT = 4;
    logic       CLK = 1'b0, SYS_RST = 1'b1, REG_WE = 1'b0, REG_RE = 1'b0, PROG_WR_REQ = 1'b0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, rd_val;
    logic [1:0] PROG_WR_ENG = 2'h0;
    logic [2:0] INSTR_DONE, EXEC_GO, EXEC_ABORT;
    logic [6:0] ENG1_PC, ENG2_PC, ENG3_PC, pc_seen;
    logic       PROG_WR_ACK, PROG_WR_NAK, PWM_FREEZE, POWER_UP, NORMAL_MODE, abort_seen = 1'b0;
    logic [3:0] dp_dly = 4'h6;
    int         n_errors = 0, cmp_count = 0, cyc = 0, go_cnt [3] = '{0, 0, 0};
    led_engine_exec_control #(.STARTUP_CNT(STARTUP_CNT)) dut (.*);
    led_datapath_model dp (.clk(CLK), .rst(SYS_RST), .dly(dp_dly), .go(EXEC_GO),
                           .abort(EXEC_ABORT), .done(INSTR_DONE));
    always #12.5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 3; i++) if (EXEC_GO[i] === 1'b1) go_cnt[i] <= go_cnt[i] + 1;
        if (EXEC_ABORT[0] === 1'b1) abort_seen <= 1'b1;
        if (cyc == 4000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_WE    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WE    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input int tries = 1);
        rd_val = ~exp;
        for (int k = 0; k < tries && rd_val !== exp; k++) begin
            @(posedge CLK);
            REG_RE   <= 1'b1;
            REG_ADDR <= a;
            @(posedge CLK);
            REG_RE   <= 1'b0;
            @(posedge CLK);
            #1 rd_val = REG_RDATA;
        end
        chk(rd_val, exp);
    endtask
    task automatic prog(input logic [1:0] e, input logic [1:0] exp);
        @(posedge CLK);
        PROG_WR_REQ <= 1'b1;
        PROG_WR_ENG <= e;
        @(posedge CLK);
        PROG_WR_REQ <= 1'b0;
        #1 chk({6'h0, PROG_WR_ACK, PROG_WR_NAK}, {6'h0, exp});
    endtask
    task automatic end_test(input string name);
        $display("test %s ended, mismatches %0d", name, n_errors);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        rd(ADDR_ENABLE_EXEC, 8'h00);
        rd(ADDR_OP_MODE, 8'h00);
        wr(ADDR_ENABLE_EXEC, 8'h15);
        rd(ADDR_ENABLE_EXEC, 8'h00);
        wr(ADDR_PC_SECOND, 8'h05);
        rd(ADDR_PC_SECOND, 8'h00);
        wr(ADDR_OP_MODE, 8'h2a);
        rd(ADDR_OP_MODE, 8'h2a);
        end_test("standby");
        wr(ADDR_ENABLE_EXEC, 8'h40);
        repeat (STARTUP_CNT + 4) @(posedge CLK);
        #1 chk({ENG2_PC[5:0], POWER_UP, NORMAL_MODE}, 8'h03);
        wr(ADDR_PC_FIRST, {1'b0, PC_LAST});
        rd(ADDR_PC_FIRST, {1'b0, PC_LAST});
        wr(ADDR_PC_THIRD, 8'h03);
        wr(ADDR_ENABLE_EXEC, 8'h50);
        rd(ADDR_ENABLE_EXEC, 8'h40, 30);
        chk({1'b0, ENG1_PC}, 8'h00);
        wr(ADDR_ENABLE_EXEC, 8'h43);
        rd(ADDR_ENABLE_EXEC, 8'h40, 30);
        chk({1'b0, ENG3_PC}, 8'h03);
        chk({7'h0, go_cnt[2] == 1 && go_cnt[1] == 0}, 8'h01);
        end_test("step");
        dp_dly <= 4'hf;
        wr(ADDR_ENABLE_EXEC, 8'h60);
        repeat (60) @(posedge CLK);
        wr(ADDR_PC_FIRST, 8'h10);
        rd(ADDR_PC_FIRST, 8'h00);
        #1 chk({7'h0, ENG1_PC > PC_ONE}, 8'h01);
        @(posedge EXEC_GO[0]);
        wr(ADDR_OP_MODE, 8'h3a);
        repeat (4) @(posedge CLK);
        #1 pc_seen = ENG1_PC;
        repeat (30) @(posedge CLK);
        #1 chk({7'h0, abort_seen}, 8'h01);
        chk({1'b0, ENG1_PC}, {1'b0, pc_seen});
        end_test("halt");
        wr(ADDR_OP_MODE, 8'h1a);
        rd(ADDR_OP_MODE, 8'h3a);
        wr(ADDR_OP_MODE, 8'h0a);
        wr(ADDR_OP_MODE, 8'h1a);
        rd(ADDR_OP_MODE, 8'h1a);
        chk({ENG1_PC, PWM_FREEZE}, {PC_ZERO, 1'b1});
        rd(ADDR_STATUS, 8'h00);
        prog(2'h0, 2'h2);
        prog(2'h1, 2'h1);
        prog(2'h3, 2'h1);
        wr(ADDR_ENABLE_EXEC, 8'h42);
        repeat (20) @(posedge CLK);
        #1 chk(8'(go_cnt[2]), 8'h01);
        wr(ADDR_OP_MODE, 8'h0a);
        repeat (20) @(posedge CLK);
        #1 chk({6'h0, PWM_FREEZE, go_cnt[2] > 1}, 8'h01);
        end_test("load");
        print_verdict();
    end
endmodule // testbench

bind led_engine_exec_control led_exec_checker #(.STARTUP_CNT(STARTUP_CNT)) chk_i (.*);
